/* File: can_acceptance_filter_config.sv */
// Acceptance filter configuration registers, filter storage and match scan with APB access
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "can_filter_map.svh"
module can_acceptance_filter_config (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic msg_valid,
  input wire can_filter_pkg::msg_id_t msg_id,
  output logic msg_ready,
  output logic result_valid,
  output logic result_accept,
  output logic result_fifo,
  output logic [7:0] match_index,
  output logic [7:0] filter_active_bit,
  output logic [7:0] fifo_select_bit,
  output logic [15:0] scale_setting
);
  localparam int FILTERS = 8;
  localparam int WORD_W = 64;

  // Byte of a filter word chosen by the low slot bits
  function automatic logic [7:0] byte_of(input logic [WORD_W-1:0] word, input logic [2:0] sel);
    byte_of = word[8*sel +: 8];
  endfunction : byte_of

  // Configuration slots 2..5 map to pair registers 0..3
  function automatic logic [1:0] cfg_sel_of(input logic [3:0] slot);
    cfg_sel_of = slot[1:0] - 2'h2;
  endfunction : cfg_sel_of

  logic [2:0] page_ff;
  logic [3:0][7:0] cfg_ff;
  logic [1:0][7:0] mode_ff;
  logic rd_wait_ff;
  logic [31:0] prdata_ff;
  can_filter_pkg::scan_state_t state_ff;
  can_filter_pkg::scan_state_t nxt_state;
  can_filter_pkg::filter_idx_t scan_cnt_ff;
  can_filter_pkg::filter_idx_t nxt_scan_cnt;
  can_filter_pkg::msg_id_t id_ff;
  can_filter_pkg::msg_id_t nxt_id;
  logic acc_ff;
  logic nxt_acc;
  logic fifo_ff;
  logic nxt_fifo;
  logic [7:0] index_ff;
  logic [7:0] nxt_index;

  logic [7:0] act_vec;
  logic [7:0] fifo_vec;
  logic [7:0] mhigh_vec;
  logic [7:0] mlow_vec;
  logic [15:0] scale_vec;

  filter_mem_if #(.DEPTH(FILTERS), .WIDTH(WORD_W)) mem_if ();

  filter_bit_mem #(
    .DEPTH(FILTERS),
    .WIDTH(WORD_W)
  ) u_mem (
    .core_clk(core_clk),
    .mem(mem_if)
  );

  // Per-filter field unpacking from the pair and mode registers
  for (genvar f = 0; f < FILTERS; f++) begin : g_unpack
    localparam int PAIR = f / 2;
    localparam int MREG = f / 4;
    localparam int MPOS = 2 * (f % 4);
    if ((f % 2) == 1) begin : g_odd
      assign act_vec[f] = cfg_ff[PAIR][`CAF_ODD_ACT_BIT];
      assign fifo_vec[f] = cfg_ff[PAIR][`CAF_ODD_FIFO_BIT];
      assign scale_vec[2*f +: 2] = cfg_ff[PAIR][`CAF_ODD_SCALE_HI:`CAF_ODD_SCALE_LO];
    end else begin : g_even
      assign act_vec[f] = cfg_ff[PAIR][`CAF_EVEN_ACT_BIT];
      assign fifo_vec[f] = cfg_ff[PAIR][`CAF_EVEN_FIFO_BIT];
      assign scale_vec[2*f +: 2] = cfg_ff[PAIR][`CAF_EVEN_SCALE_HI:`CAF_EVEN_SCALE_LO];
    end
    assign mhigh_vec[f] = mode_ff[MREG][MPOS + `CAF_MODE_HIGH_BIT];
    assign mlow_vec[f] = mode_ff[MREG][MPOS + `CAF_MODE_LOW_BIT];
  end

  assign filter_active_bit = act_vec;
  assign fifo_select_bit = fifo_vec;
  assign scale_setting = scale_vec;

  // APB decode
  wire logic apb_access = psel && penable;
  wire logic [3:0] slot = paddr[5:2];
  wire logic [1:0] cfg_sel = cfg_sel_of(slot);
  wire logic cfg_page = page_ff[`CAF_PAGE_CFG_BIT];
  wire logic is_page = (paddr == `CAF_OFS_PAGE_SEL);
  wire logic is_stat = (paddr == `CAF_OFS_MATCH_STAT);
  wire logic in_win = (paddr[11:6] == `CAF_WIN_BLOCK) && (paddr[1:0] == 2'h0);
  wire logic win_mem = in_win && !cfg_page;
  wire logic win_mode = in_win && cfg_page && (slot <= `CAF_SLOT_MODE_UPPER);
  wire logic win_cfg = in_win && cfg_page && (slot >= `CAF_SLOT_CFG_FIRST)
                       && (slot <= `CAF_SLOT_CFG_LAST);
  wire logic mapped = is_page || is_stat || in_win;

  // Mapped reads take one wait state so that the stored byte can come from a register
  assign pready = pwrite || !mapped || rd_wait_ff;
  assign pslverr = apb_access && !mapped;
  assign prdata = prdata_ff;

  wire logic wr_fire = apb_access && pwrite && pready && pstrb[0];
  wire logic page_we = wr_fire && is_page;
  wire logic cfg_we = wr_fire && win_cfg;
  wire logic mode_we = wr_fire && win_mode;
  wire logic rd_first = apb_access && !pwrite && mapped && !rd_wait_ff;
  wire logic busy = (state_ff != can_filter_pkg::SCAN_IDLE);

  wire logic [31:0] stat_word = {21'h000000, busy, fifo_ff, acc_ff, index_ff};
  wire logic [31:0] rd_mux =
    is_page ? {29'h00000000, page_ff} :
    is_stat ? stat_word :
    win_mem ? {24'h000000, byte_of(mem_if.rd_a_data, slot[2:0])} :
    win_mode ? {24'h000000, mode_ff[slot[0]]} :
    win_cfg ? {24'h000000, cfg_ff[cfg_sel]} :
    32'h00000000;

  // Filter-bit window: page picks the pair, slot bit 3 the filter, slot[2:0] the byte
  // Editing bytes of an active filter can race the scan below
  assign mem_if.wr_en = wr_fire && win_mem;
  assign mem_if.wr_idx = {page_ff[1:0], slot[3]};
  assign mem_if.wr_be = 8'h01 << slot[2:0];
  assign mem_if.wr_data = {8{pwdata[7:0]}};
  assign mem_if.rd_a_idx = {page_ff[1:0], slot[3]};
  assign mem_if.rd_b_idx = (state_ff == can_filter_pkg::SCAN_RUN) ?
                           3'(scan_cnt_ff + 3'h1) : 3'h0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      page_ff <= `CAF_PAGE_RST;
      cfg_ff <= {4{`CAF_CFG_RST}};
      mode_ff <= {2{`CAF_MODE_RST}};
    end else begin
      if (page_we) begin
        page_ff <= pwdata[2:0];
      end
      // FIFO and scale bits are expected to change only in init mode
      if (cfg_we) begin
        cfg_ff[cfg_sel] <= pwdata[7:0];
      end
      if (mode_we) begin
        mode_ff[slot[0]] <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_wait_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      rd_wait_ff <= rd_first;
      if (rd_first) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  // Match scan: one filter per cycle, lowest index wins
  logic hit;
  filter_match_unit u_match (
    .filter_word(mem_if.rd_b_data),
    .high_half_mode(mhigh_vec[scan_cnt_ff]),
    .low_half_mode(mlow_vec[scan_cnt_ff]),
    .filter_active_bit(act_vec[scan_cnt_ff]),
    .msg_id(id_ff),
    .hit(hit)
  );

  wire logic cur_fifo = fifo_vec[scan_cnt_ff];
  assign msg_ready = (state_ff == can_filter_pkg::SCAN_IDLE);
  assign result_valid = (state_ff == can_filter_pkg::SCAN_DONE);
  assign result_accept = acc_ff;
  assign result_fifo = fifo_ff;
  assign match_index = index_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_scan_cnt = scan_cnt_ff;
    nxt_id = id_ff;
    nxt_acc = acc_ff;
    nxt_fifo = fifo_ff;
    nxt_index = index_ff;
    case (state_ff)
      can_filter_pkg::SCAN_IDLE: begin
        if (msg_valid) begin
          nxt_state = can_filter_pkg::SCAN_RUN;
          nxt_scan_cnt = 3'h0;
          nxt_id = msg_id;
        end
      end
      can_filter_pkg::SCAN_RUN: begin
        if (hit) begin
          nxt_state = can_filter_pkg::SCAN_DONE;
          nxt_acc = 1'b1;
          nxt_fifo = cur_fifo;
          nxt_index = {5'h00, scan_cnt_ff};
        end else if (scan_cnt_ff == `CAF_LAST_FILTER) begin
          nxt_state = can_filter_pkg::SCAN_DONE;
          nxt_acc = 1'b0;
          nxt_fifo = 1'b0;
          nxt_index = `CAF_NO_MATCH_INDEX;
        end else begin
          nxt_scan_cnt = 3'(scan_cnt_ff + 3'h1);
        end
      end
      can_filter_pkg::SCAN_DONE: begin
        nxt_state = can_filter_pkg::SCAN_IDLE;
      end
      default: begin
        nxt_state = can_filter_pkg::SCAN_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= can_filter_pkg::SCAN_IDLE;
      scan_cnt_ff <= 3'h0;
      id_ff <= 16'h0000;
      acc_ff <= 1'b0;
      fifo_ff <= 1'b0;
      index_ff <= `CAF_NO_MATCH_INDEX;
    end else begin
      state_ff <= nxt_state;
      scan_cnt_ff <= nxt_scan_cnt;
      id_ff <= nxt_id;
      acc_ff <= nxt_acc;
      fifo_ff <= nxt_fifo;
      index_ff <= nxt_index;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  wire logic scanning = (state_ff == can_filter_pkg::SCAN_RUN);
  wire logic [15:0] hi_first = {mem_if.rd_b_data[7:0], mem_if.rd_b_data[15:8]};
  wire logic [15:0] lo_first = {mem_if.rd_b_data[39:32], mem_if.rd_b_data[47:40]};
  wire logic [15:0] lo_mask = {mem_if.rd_b_data[55:48], mem_if.rd_b_data[63:56]};

  sequence seq_msg_taken;
    msg_valid && msg_ready;
  endsequence
  sequence seq_result_out;
    result_valid;
  endsequence

  a_fifo_route: assert property (
    scanning && hit |=> result_valid && result_accept && (result_fifo == $past(cur_fifo)))
    else $error("accepted message routed to wrong receive FIFO");

  a_inactive_skip: assert property (
    scanning && !act_vec[scan_cnt_ff] |-> !hit)
    else $error("inactive filter produced a hit");

  a_list_hit: assert property (
    scanning && act_vec[scan_cnt_ff] && mhigh_vec[scan_cnt_ff] && (id_ff == hi_first)
    |-> hit)
    else $error("listed identifier not accepted");

  a_mask_hit: assert property (
    scanning && act_vec[scan_cnt_ff] && !mlow_vec[scan_cnt_ff]
    && (((id_ff ^ lo_first) & lo_mask) == 16'h0000) |-> hit)
    else $error("masked identifier not accepted");

  a_cfg_reset: assert property (
    $past(rst) |-> (cfg_ff == 32'h00000000) && (mode_ff == 16'h0000) && (act_vec == 8'h00))
    else $error("configuration not cleared by reset");

  a_scale_field: assert property (
    cfg_we && (slot == `CAF_SLOT_CFG_FIRST)
    |=> (scale_setting[3:2] == $past(pwdata[6:5])) && (scale_setting[1:0] == $past(pwdata[2:1])))
    else $error("scale field taken from wrong bits");

  a_mode_field: assert property (
    mode_we && (slot == `CAF_SLOT_MODE_UPPER)
    |=> (mhigh_vec[7] == $past(pwdata[7])) && (mlow_vec[4] == $past(pwdata[0])))
    else $error("mode bits taken from wrong positions");

  a_cfg_hold: assert property (
    !cfg_we && !mode_we |=> $stable(cfg_ff) && $stable(mode_ff))
    else $error("configuration changed without a write");

  a_page_split: assert property (
    wr_fire && in_win && cfg_page |-> !mem_if.wr_en)
    else $error("configuration page write reached filter storage");

  a_index_rec: assert property (
    seq_result_out |-> (result_accept ? (match_index[7:3] == 5'h00)
                                      : (match_index == `CAF_NO_MATCH_INDEX)))
    else $error("match index inconsistent with result");

  a_scan_bound: assert property (
    seq_msg_taken |=> !msg_ready [*2] ##[0:7] seq_result_out)
    else $error("scan did not finish in nine cycles");

endmodule : can_acceptance_filter_config
`default_nettype wire

/* File: can_filter_map.svh */
// Register offsets, field positions and reset values of the acceptance filter block
`ifndef CAN_FILTER_MAP_SVH
`define CAN_FILTER_MAP_SVH
`define CAF_OFS_PAGE_SEL 12'h000
`define CAF_OFS_MATCH_STAT 12'h004
`define CAF_WIN_BLOCK 6'h01
`define CAF_SLOT_MODE_LOWER 4'h0
`define CAF_SLOT_MODE_UPPER 4'h1
`define CAF_SLOT_CFG_FIRST 4'h2
`define CAF_SLOT_CFG_LAST 4'h5
`define CAF_PAGE_CFG_BIT 2
`define CAF_PAGE_RST 3'h0
`define CAF_CFG_RST 8'h00
`define CAF_MODE_RST 8'h00
`define CAF_ODD_FIFO_BIT 7
`define CAF_ODD_SCALE_HI 6
`define CAF_ODD_SCALE_LO 5
`define CAF_ODD_ACT_BIT 4
`define CAF_EVEN_FIFO_BIT 3
`define CAF_EVEN_SCALE_HI 2
`define CAF_EVEN_SCALE_LO 1
`define CAF_EVEN_ACT_BIT 0
`define CAF_MODE_HIGH_BIT 1
`define CAF_MODE_LOW_BIT 0
`define CAF_STAT_ACC_BIT 8
`define CAF_STAT_FIFO_BIT 9
`define CAF_STAT_BUSY_BIT 10
`define CAF_NO_MATCH_INDEX 8'hFF
`define CAF_LAST_FILTER 3'h7
`endif

/* File: can_filter_pkg.sv */
// Types shared by the acceptance filter modules
`default_nettype none
package can_filter_pkg;
  typedef enum logic [1:0] {
    SCAN_IDLE,
    SCAN_RUN,
    SCAN_DONE
  } scan_state_t;
  typedef logic [2:0] filter_idx_t;
  typedef logic [15:0] msg_id_t;
endpackage : can_filter_pkg
`default_nettype wire

/* File: filter_mem_if.sv */
// Write port and two read ports of the filter-bit storage
`timescale 1ns/10ps
`default_nettype none
interface filter_mem_if #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 64
);
  localparam int IDX_W = $clog2(DEPTH);
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [WIDTH/8-1:0] wr_be;
  logic [WIDTH-1:0] wr_data;
  logic [IDX_W-1:0] rd_a_idx;
  logic [WIDTH-1:0] rd_a_data;
  logic [IDX_W-1:0] rd_b_idx;
  logic [WIDTH-1:0] rd_b_data;
  modport owner (
    output wr_en, wr_idx, wr_be, wr_data, rd_a_idx, rd_b_idx,
    input rd_a_data, rd_b_data
  );
  modport store (
    input wr_en, wr_idx, wr_be, wr_data, rd_a_idx, rd_b_idx,
    output rd_a_data, rd_b_data
  );
endinterface : filter_mem_if
`default_nettype wire

/* File: filter_bit_mem.sv */
// Filter-bit storage: one word per filter, byte writes, two registered read ports
`timescale 1ns/10ps
`default_nettype none
module filter_bit_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 64
) (
  input wire logic core_clk,
  filter_mem_if.store mem
);
  // No reset: contents are undefined until software writes them
  logic [WIDTH-1:0] cells_ff [DEPTH];

  always_ff @(posedge core_clk) begin
    if (mem.wr_en) begin
      for (int b = 0; b < WIDTH / 8; b++) begin
        if (mem.wr_be[b]) begin
          cells_ff[mem.wr_idx][8*b +: 8] <= mem.wr_data[8*b +: 8];
        end
      end
    end
    mem.rd_a_data <= cells_ff[mem.rd_a_idx];
    mem.rd_b_data <= cells_ff[mem.rd_b_idx];
  end
endmodule : filter_bit_mem
`default_nettype wire

/* File: filter_match_unit.sv */
// Compares one identifier against the eight filter bytes of one filter
`timescale 1ns/10ps
`default_nettype none
module filter_match_unit (
  input wire logic [63:0] filter_word,
  input wire logic high_half_mode,
  input wire logic low_half_mode,
  input wire logic filter_active_bit,
  input wire can_filter_pkg::msg_id_t msg_id,
  output logic hit
);
  // Half = four bytes; first pair is an identifier, second pair an identifier or mask
  function automatic logic half_hit(input logic [31:0] half, input logic list_mode,
                                    input can_filter_pkg::msg_id_t id);
    logic [15:0] first;
    logic [15:0] second;
    first = {half[7:0], half[15:8]};
    second = {half[23:16], half[31:24]};
    if (list_mode) begin
      half_hit = (id == first) || (id == second);
    end else begin
      half_hit = ((id ^ first) & second) == 16'h0000;
    end
  endfunction : half_hit

  wire logic high_hit = half_hit(filter_word[31:0], high_half_mode, msg_id);
  wire logic low_hit = half_hit(filter_word[63:32], low_half_mode, msg_id);

  assign hit = filter_active_bit && (high_hit || low_hit);
endmodule : filter_match_unit
`default_nettype wire

/* File: can_rx_path_model.sv */
// Receive-path model that offers identifiers to the filter and times the answer
`timescale 1ns/10ps
`default_nettype none
module can_rx_path_model (
  input wire logic core_clk,
  input wire logic msg_ready,
  input wire logic result_valid,
  output logic msg_valid,
  output can_filter_pkg::msg_id_t msg_id
);
  initial begin
    msg_valid = 1'b0;
    msg_id = 16'h0000;
  end

  // Holds the identifier until taken, then counts cycles up to the result pulse
  task automatic send(input can_filter_pkg::msg_id_t id, output int lat);
    @(posedge core_clk);
    msg_valid <= 1'b1;
    msg_id <= id;
    do @(posedge core_clk); while (msg_ready !== 1'b1);
    msg_valid <= 1'b0;
    // A released identifier must not keep showing the offered value
    msg_id <= ~id;
    lat = 0;
    do begin
      @(posedge core_clk);
      lat++;
    end while (result_valid !== 1'b1 && lat < 20);
  endtask : send
endmodule : can_rx_path_model
`default_nettype wire

/* File: test_can_acceptance_filter_config.sv */
// Self-checking bench for the filter registers and the identifier match scan
`timescale 1ns/10ps
`default_nettype none
`define check_eq(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin failures++; \
  $display("mismatch %s exp %h got %h", nm, exp, got); end end
module test_can_acceptance_filter_config;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, msg_valid, msg_ready, result_valid, result_accept, result_fifo;
  logic [7:0] match_index, filter_active_bit, fifo_select_bit;
  logic [15:0] scale_setting;
  can_filter_pkg::msg_id_t msg_id;
  logic [7:0] pat [8] = '{8'hA0, 8'h5A, 8'hB0, 8'hC3, 8'hC0, 8'h00, 8'hFF, 8'h00};
  int failures = 0;
  int n_tests = 0;
  int lat;

  always #12.5 core_clk = ~core_clk;

  can_acceptance_filter_config DUT (.core_clk(core_clk), .rst(rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .msg_valid(msg_valid),
    .msg_id(msg_id), .msg_ready(msg_ready), .result_valid(result_valid),
    .result_accept(result_accept), .result_fifo(result_fifo), .match_index(match_index),
    .filter_active_bit(filter_active_bit), .fifo_select_bit(fifo_select_bit),
    .scale_setting(scale_setting));

  can_rx_path_model rx (.core_clk(core_clk), .msg_ready(msg_ready),
    .result_valid(result_valid), .msg_valid(msg_valid), .msg_id(msg_id));

  task automatic finish_test;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  // One APB transfer: setup, then access held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) failures++;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00, 4'hF);
    `check_eq($sformatf("reg %h", a), e, rd)
  endtask : rchk

  function automatic logic [11:0] sa(input int s);
    return 12'h040 + 12'(s * 4);
  endfunction : sa

  task automatic mchk(input can_filter_pkg::msg_id_t id, input logic [7:0] idx,
                      input logic fifo);
    rx.send(id, lat);
    `check_eq("index", idx, match_index)
    `check_eq("accept", idx != 8'hFF, result_accept)
    `check_eq("fifo", fifo, result_fifo)
    `check_eq("latency", (idx == 8'hFF) ? 9 : idx + 2, lat)
  endtask : mchk

  initial begin
    #250000;
    failures++;
    finish_test();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    `check_eq("active", 8'h00, filter_active_bit)
    rchk(12'h000, 8'h00);
    wr(12'h000, 8'h04);
    for (int s = 0; s < 6; s++) begin
      rchk(sa(s), 8'h00);
    end
    rchk(sa(6), 8'h00);
    // Filter bytes are loaded while every filter is still inactive
    for (int f = 0; f < 8; f++) begin
      wr(12'h000, 8'(f / 2));
      for (int b = 0; b < 8; b++) begin
        wr(sa((f % 2) * 8 + b), pat[b] + 8'((b < 6 && b % 2 == 0) ? f : 0));
      end
    end
    rchk(sa(8), 8'hA7);
    wr(12'h000, 8'h04);
    wr(sa(0), 8'hAA);
    wr(sa(1), 8'hAA);
    mchk({8'hA3, 8'h5A}, 8'hFF, 1'b0);
    for (int s = 2; s < 6; s++) begin
      wr(sa(s), 8'hB3);
    end
    // Outputs follow the register written at the last edge
    @(posedge core_clk);
    `check_eq("active", 8'hFF, filter_active_bit)
    `check_eq("fifo sel", 8'hAA, fifo_select_bit)
    `check_eq("scale", 16'h5555, scale_setting)
    for (int f = 0; f < 8; f++) begin
      mchk({8'hA0 + 8'(f), 8'h5A}, 8'(f), f[0]);
      mchk({8'hB0 + 8'(f), 8'hC3}, 8'(f), f[0]);
      mchk({8'hC0 + 8'(f), 8'h37}, 8'(f), f[0]);
      mchk({8'hC8 + 8'(f), 8'h00}, 8'hFF, 1'b0);
      mchk({8'hA0 + 8'(f), 8'h5B}, 8'hFF, 1'b0);
    end
    mchk(16'hA55A, 8'h05, 1'b1);
    rchk(12'h004, 32'h00000305);
    wr(sa(3), 8'hB2);
    @(posedge core_clk);
    `check_eq("active", 8'hFB, filter_active_bit)
    mchk(16'hA25A, 8'hFF, 1'b0);
    wr(sa(3), 8'hB3);
    wr(sa(0), 8'h00);
    mchk(16'hEF66, 8'h00, 1'b0);
    wr(sa(0), 8'hAA);
    wr(sa(1), 8'h00);
    mchk(16'hEF66, 8'h04, 1'b0);
    wr(sa(1), 8'hAA);
    wr(sa(0), 8'h55);
    mchk(16'hC000, 8'h00, 1'b0);
    mchk(16'hC037, 8'hFF, 1'b0);
    rchk(sa(0), 8'h55);
    for (int s = 2; s < 6; s++) begin
      rchk(sa(s), 8'hB3);
    end
    apb(1'b1, 12'h000, 8'h01, 4'h0);
    rchk(12'h000, 8'h04);
    apb(1'b0, 12'h008, 8'h00, 4'hF);
    `check_eq("slverr", 1'b1, err)
    wr(12'h000, 8'h07);
    rchk(sa(2), 8'hB3);
    // Reset while the scan is idle clears configuration, page and match record again
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    `check_eq("active", 8'h00, filter_active_bit)
    `check_eq("index", 8'hFF, match_index)
    rchk(12'h000, 8'h00);
    wr(12'h000, 8'h04);
    rchk(sa(3), 8'h00);
    finish_test();
  end
endmodule : test_can_acceptance_filter_config
`default_nettype wire
